// ===== src/rwc_pkg.sv
// package for the reset and watchdog controller
// assumes a 125 MHz core clock and an 80 kHz low-frequency oscillator
package rwc_pkg;
    localparam int          CORE_CLK_KHZ      = 125000;
    localparam int          LFO_KHZ           = 80;
    // lfo tick period in core cycles, rounded down
    localparam int          LFO_DIV           = CORE_CLK_KHZ / LFO_KHZ;
    localparam int          LFO_DIV_W         = 11;
    localparam int          NUM_SOURCES       = 8;
    localparam int          NUM_PORT_PINS     = 18;
    localparam int          WDT_W             = 24;
    localparam logic [2:0]  WDT_INTERVAL_MAX  = 3'h7;
    localparam logic [2:0]  WDT_INTERVAL_MIN  = 3'h0;
    // interval n times out after 2^(WDT_BASE_SHIFT+n) lfo ticks
    localparam int          WDT_BASE_SHIFT    = 10;
    localparam logic [15:0] RESET_VECTOR      = 16'h0000;
    localparam logic [1:0]  SYSCLK_SEL_INT    = 2'h0;
    // source index in the cause vector
    localparam int          SRC_POR           = 0;
    localparam int          SRC_PIN           = 1;
    localparam int          SRC_CMP           = 2;
    localparam int          SRC_SW            = 3;
    localparam int          SRC_MON           = 4;
    localparam int          SRC_WDT           = 5;
    localparam int          SRC_MCD           = 6;
    localparam int          SRC_FLASH         = 7;
    typedef enum logic [1:0]
    {
        RWC_RUN     = 2'b00,
        RWC_HOLD    = 2'b01,
        RWC_RELEASE = 2'b10
    } rwc_state_t;
endpackage

// ===== src/rwc_reset_ctrl.sv
// reset source collector and watchdog for the core
// assumes core_clk runs free; source inputs other than sw_reset_req may be asynchronous, lfo from a pin
`timescale 1ns/1ns
// Behaviour
// - watchdog overflow puts the device into reset
// - after any reset watchdog runs, enabled, at the largest interval
// - software may disable or lock the watchdog; lock ignores disable
// - while locked all watchdog setting changes are blocked
// - watchdog reset never drives the external reset pin
// - watchdog counts lfo ticks with a programmable interval
// - reset halts the core
// - registers take reset values on every reset; the cause record is replaced by each reset
// - port latches go to one, open-drain, on reset
// - weak pull-ups on during and after reset
// - reset disables interrupts and timers
// - reset leaves ram contents untouched
// - power-on and monitor resets drive the reset pin low
// - leaving reset clears the pc and selects the internal oscillator
// - first fetch after reset is from address zero
// - eight sources can assert reset
module rwc_reset_ctrl
    import rwc_pkg::*;
(
    input  wire logic                     core_clk,
    input  wire logic                     rst_n,
    input  wire logic                     lfo_clk,
    input  wire logic                     reset_pin_n_in,
    input  wire logic                     cmp_reset_req,
    input  wire logic                     sw_reset_req,
    input  wire logic                     supply_monitor_fail,
    input  wire logic                     missing_clk_req,
    input  wire logic                     flash_error_req,
    input  wire logic                     wdt_restart,
    input  wire logic                     wdt_disable,
    input  wire logic                     wdt_lock,
    input  wire logic                     wdt_interval_wr,
    input  wire logic [2:0]               wdt_interval_in,
    output logic                          reset_pin_n_out,
    output logic                          reset_pin_n_oe,
    output logic                          sys_reset_n,
    output logic                          por_reset_n,
    output logic                          core_halt,
    output logic                          irq_disable,
    output logic                          timer_disable,
    output logic                          ram_keep,
    output logic [NUM_PORT_PINS-1:0]      port_latch,
    output logic [NUM_PORT_PINS-1:0]      port_open_drain,
    output logic                          weak_pullup_en,
    output logic                          pc_clear,
    output logic [15:0]                   fetch_addr,
    output logic [1:0]                    sysclk_sel,
    output logic                          wdt_enabled,
    output logic                          wdt_locked,
    output logic [2:0]                    wdt_interval,
    output logic [NUM_SOURCES-1:0]        reset_cause
);
    logic                   rst_s1;
    logic                   rst_s2;
    logic [4:0]             src_s1;
    logic [4:0]             src_s2;
    logic                   lfo_s1;
    logic                   lfo_s2;
    logic                   lfo_d;
    logic                   lfo_tick;
    logic [WDT_W-1:0]       wdt_cnt;
    logic                   wdt_ovf;
    logic                   wdt_fire;
    logic                   any_src;
    logic                   pin_drive;
    logic [1:0]             pin_hist;
    logic                   pin_mask;
    logic [NUM_SOURCES-1:0] src_vec;
    rwc_state_t             state;
    rwc_state_t             next_state;

    // por is the raw rst_n; its release passes two flops
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
        end
        else
        begin
            rst_s1 <= 1'b1;
            rst_s2 <= rst_s1;
        end
    end

    // asynchronous sources synchronised before use
    always_ff @(posedge core_clk or negedge rst_s2)
    begin
        if (!rst_s2)
        begin
            src_s1 <= 5'h00;
            src_s2 <= 5'h00;
            lfo_s1 <= 1'b0;
            lfo_s2 <= 1'b0;
            lfo_d  <= 1'b0;
        end
        else
        begin
            src_s1 <= {flash_error_req, missing_clk_req, supply_monitor_fail,
                       cmp_reset_req, !reset_pin_n_in};
            src_s2 <= src_s1;
            lfo_s1 <= lfo_clk;
            lfo_s2 <= lfo_s1;
            lfo_d  <= lfo_s2;
        end
    end

    assign lfo_tick = lfo_s2 && !lfo_d;

    // pin sample feeds back from our own drive; ignore it while we pull low
    always_comb
    begin
        src_vec            = '0;
        src_vec[SRC_POR]   = !rst_s2;
        src_vec[SRC_PIN]   = src_s2[0] && !pin_mask;
        src_vec[SRC_CMP]   = src_s2[1];
        src_vec[SRC_SW]    = sw_reset_req;
        src_vec[SRC_MON]   = src_s2[2];
        src_vec[SRC_WDT]   = wdt_fire;
        src_vec[SRC_MCD]   = src_s2[3];
        src_vec[SRC_FLASH] = src_s2[4];
    end

    assign any_src = |src_vec;

    always_comb
    begin
        next_state = state;
        case (state)
            RWC_RUN:
            begin
                if (any_src)
                begin
                    next_state = RWC_HOLD;
                end
            end
            RWC_HOLD:
            begin
                if (!any_src)
                begin
                    next_state = RWC_RELEASE;
                end
            end
            RWC_RELEASE:
            begin
                next_state = any_src ? RWC_HOLD : RWC_RUN;
            end
            default:
            begin
                next_state = RWC_HOLD;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_s2)
    begin
        if (!rst_s2)
        begin
            state <= RWC_HOLD;
        end
        else
        begin
            state <= next_state;
        end
    end

    // latch causes; por leaves only the por bit, other resets replace the record
    always_ff @(posedge core_clk or negedge rst_s2)
    begin
        if (!rst_s2)
        begin
            reset_cause <= '0;
            reset_cause[SRC_POR] <= 1'b1;
        end
        else if (state == RWC_RUN && any_src)
        begin
            reset_cause <= src_vec;
        end
    end

    // pin driven low only for power-on and monitor resets, never watchdog
    always_ff @(posedge core_clk or negedge rst_s2)
    begin
        if (!rst_s2)
        begin
            pin_drive <= 1'b1;
        end
        else if (state == RWC_RELEASE || state == RWC_RUN)
        begin
            pin_drive <= src_vec[SRC_MON];
        end
        else if (src_vec[SRC_MON])
        begin
            pin_drive <= 1'b1;
        end
    end

    // synchronised pin lags our drive by two edges; without this mask
    // releasing the pin would re-trigger a pin reset
    always_ff @(posedge core_clk or negedge rst_s2)
    begin
        if (!rst_s2)
        begin
            pin_hist <= 2'h3;
        end
        else
        begin
            pin_hist <= {pin_hist[0], pin_drive};
        end
    end

    assign pin_mask = pin_drive || (|pin_hist);

    assign reset_pin_n_out = 1'b0;
    assign reset_pin_n_oe  = pin_drive || !rst_s2;

    // watchdog settings; reset restores enabled, unlocked, max interval
    always_ff @(posedge core_clk or negedge rst_s2)
    begin
        if (!rst_s2)
        begin
            wdt_enabled  <= 1'b1;
            wdt_locked   <= 1'b0;
            wdt_interval <= WDT_INTERVAL_MAX;
        end
        else if (state != RWC_RUN)
        begin
            wdt_enabled  <= 1'b1;
            wdt_locked   <= 1'b0;
            wdt_interval <= WDT_INTERVAL_MAX;
        end
        else if (!wdt_locked)
        begin
            if (wdt_lock)
            begin
                wdt_locked  <= 1'b1;
                wdt_enabled <= 1'b1;
            end
            else if (wdt_disable)
            begin
                wdt_enabled <= 1'b0;
            end
            if (wdt_interval_wr && !wdt_lock)
            begin
                wdt_interval <= wdt_interval_in;
            end
        end
    end

    assign wdt_ovf = wdt_cnt[WDT_BASE_SHIFT + 32'(wdt_interval)];

    // counts only on lfo ticks; restart wins over an overflow tick
    always_ff @(posedge core_clk or negedge rst_s2)
    begin
        if (!rst_s2)
        begin
            wdt_cnt  <= '0;
            wdt_fire <= 1'b0;
        end
        else if (state != RWC_RUN || !wdt_enabled || wdt_restart)
        begin
            wdt_cnt  <= '0;
            wdt_fire <= 1'b0;
        end
        else if (wdt_ovf)
        begin
            wdt_fire <= 1'b1;
        end
        else if (lfo_tick)
        begin
            wdt_cnt <= wdt_cnt + 1'b1;
        end
    end

    // reset-state effects on the rest of the chip
    always_comb
    begin
        sys_reset_n     = (state == RWC_RUN);
        por_reset_n     = rst_s2;
        core_halt       = (state != RWC_RUN);
        irq_disable     = core_halt;
        timer_disable   = core_halt;
        ram_keep        = 1'b1;
        weak_pullup_en  = 1'b1;
        pc_clear        = core_halt;
        fetch_addr      = RESET_VECTOR;
    end

    // latches and clock select held at defaults while in reset
    always_ff @(posedge core_clk or negedge rst_s2)
    begin
        if (!rst_s2)
        begin
            port_latch      <= '1;
            port_open_drain <= '1;
            sysclk_sel      <= SYSCLK_SEL_INT;
        end
        else if (state != RWC_RUN)
        begin
            port_latch      <= '1;
            port_open_drain <= '1;
            sysclk_sel      <= SYSCLK_SEL_INT;
        end
    end
endmodule

// ===== verification/rwc_reset_props.sv
// assertions on the reset controller ports
// assumes a single core_clk domain, bound into rwc_reset_ctrl
`timescale 1ns/1ns
module rwc_reset_props
    import rwc_pkg::*;
(
    input wire logic                     core_clk,
    input wire logic                     rst_n,
    input wire logic                     sw_reset_req,
    input wire logic                     supply_monitor_fail,
    input wire logic                     reset_pin_n_oe,
    input wire logic                     sys_reset_n,
    input wire logic                     core_halt,
    input wire logic                     irq_disable,
    input wire logic                     timer_disable,
    input wire logic                     pc_clear,
    input wire logic                     ram_keep,
    input wire logic                     weak_pullup_en,
    input wire logic [NUM_PORT_PINS-1:0] port_latch,
    input wire logic [NUM_PORT_PINS-1:0] port_open_drain,
    input wire logic [15:0]              fetch_addr,
    input wire logic [1:0]               sysclk_sel,
    input wire logic                     wdt_enabled,
    input wire logic                     wdt_locked,
    input wire logic [2:0]               wdt_interval,
    input wire logic [NUM_SOURCES-1:0]   reset_cause
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_halt_core: assert property
        (!sys_reset_n |-> core_halt && irq_disable && timer_disable && pc_clear)
        else $error("core running in reset");
    a_latch_ones: assert property
        (!sys_reset_n [*2] |-> &port_latch && &port_open_drain)
        else $error("port latches not ones");
    a_pullup_ram_vec: assert property
        (weak_pullup_en && ram_keep && fetch_addr == RESET_VECTOR)
        else $error("pullup, ram or vector wrong");
    a_mon_pin: assert property
        (supply_monitor_fail [*5] |-> reset_pin_n_oe && !sys_reset_n)
        else $error("monitor reset not on pin");
    a_wdt_no_pin: assert property
        ($rose(reset_cause[SRC_WDT]) && !reset_cause[SRC_MON] |-> !reset_pin_n_oe)
        else $error("watchdog reset drove pin");
    a_sw_takes: assert property
        (sw_reset_req && sys_reset_n |-> ##[1:3] !sys_reset_n)
        else $error("software reset not taken");
    a_lock_holds: assert property
        (wdt_locked && sys_reset_n ##1 sys_reset_n |-> wdt_locked && wdt_enabled
            && $stable(wdt_interval))
        else $error("locked watchdog changed");
    a_release_clean: assert property
        ($rose(sys_reset_n) |-> !sw_reset_req && !supply_monitor_fail && wdt_enabled
            && !wdt_locked && wdt_interval == WDT_INTERVAL_MAX && sysclk_sel == SYSCLK_SEL_INT)
        else $error("bad state on release");

    c_wdt: cover property ($rose(reset_cause[SRC_WDT]));
    c_mon: cover property (supply_monitor_fail && reset_pin_n_oe);
    c_lock: cover property ($rose(wdt_locked));
endmodule

bind rwc_reset_ctrl rwc_reset_props rwc_props_u (.core_clk, .rst_n, .sw_reset_req,
    .supply_monitor_fail, .reset_pin_n_oe, .sys_reset_n, .core_halt, .irq_disable,
    .timer_disable, .pc_clear, .ram_keep, .weak_pullup_en, .port_latch, .port_open_drain,
    .fetch_addr, .sysclk_sel, .wdt_enabled, .wdt_locked, .wdt_interval, .reset_cause);

// ===== verification/rwc_far_side.sv
// far side: free-running lfo, pulled-up reset pin, kicking software
// assumes inputs change on falling core_clk edges
`timescale 1ns/1ns
module rwc_far_side
(
    input  wire logic core_clk,
    input  wire logic kick_en,
    input  wire logic pin_pull_low,
    input  wire logic reset_pin_n_out,
    input  wire logic reset_pin_n_oe,
    output logic      lfo_clk,
    output logic      wdt_restart,
    output logic      reset_pin_n_in
);
    logic [7:0] kick_cnt = 8'h00;
    // sped-up oscillator so a short interval fits the run
    initial
    begin
        lfo_clk = 1'h0;
        forever #16 lfo_clk = ~lfo_clk;
    end
    // kick well inside the shortest interval
    always @(negedge core_clk)
    begin
        kick_cnt <= kick_cnt + 8'h01;
        wdt_restart <= kick_en && kick_cnt == 8'h00;
    end
    // open-drain pin with pull-up
    assign reset_pin_n_in = (reset_pin_n_oe && !reset_pin_n_out) || pin_pull_low ? 1'h0 : 1'h1;
endmodule

// ===== verification/tb_reset_and_watchdog_control.sv
// self-checking bench for the reset controller
// assumes rwc_far_side supplies lfo, reset pin and watchdog kicks
`timescale 1ns/1ns
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_reset_and_watchdog_control
    import rwc_pkg::*;
;
    logic rst_n = 1'h0, kick_en = 1'h0, wdt_disable = 1'h0, wdt_lock = 1'h0;
    logic wdt_interval_wr = 1'h0, core_clk, lfo_clk, reset_pin_n_in, wdt_restart;
    logic cmp_reset_req, sw_reset_req, supply_monitor_fail, missing_clk_req, flash_error_req;
    logic reset_pin_n_out, reset_pin_n_oe, sys_reset_n, por_reset_n, core_halt, irq_disable;
    logic timer_disable, ram_keep, weak_pullup_en, pc_clear, wdt_enabled, wdt_locked;
    logic [2:0]               wdt_interval_in = 3'h0, wdt_interval;
    logic [NUM_PORT_PINS-1:0] port_latch, port_open_drain;
    logic [15:0]              fetch_addr;
    logic [1:0]               sysclk_sel;
    logic [NUM_SOURCES-1:0]   reset_cause, req = 8'h00;
    int                       err_total, cmp_count, cycles;
    // oe expected beside each source request
    logic [8:0]               rows [6] = '{9'h002, 9'h004, 9'h008, 9'h110, 9'h040, 9'h080};
    assign cmp_reset_req = req[SRC_CMP];
    assign sw_reset_req = req[SRC_SW];
    assign supply_monitor_fail = req[SRC_MON];
    assign missing_clk_req = req[SRC_MCD];
    assign flash_error_req = req[SRC_FLASH];
    rwc_reset_ctrl dut_u
    (
        .core_clk, .rst_n, .lfo_clk, .reset_pin_n_in, .cmp_reset_req, .sw_reset_req,
        .supply_monitor_fail, .missing_clk_req, .flash_error_req, .wdt_restart, .wdt_disable,
        .wdt_lock, .wdt_interval_wr, .wdt_interval_in, .reset_pin_n_out, .reset_pin_n_oe,
        .sys_reset_n, .por_reset_n, .core_halt, .irq_disable, .timer_disable, .ram_keep,
        .port_latch, .port_open_drain, .weak_pullup_en, .pc_clear, .fetch_addr, .sysclk_sel,
        .wdt_enabled, .wdt_locked, .wdt_interval, .reset_cause
    );
    rwc_far_side far_u
    (
        .core_clk, .kick_en, .pin_pull_low(req[SRC_PIN]), .reset_pin_n_out, .reset_pin_n_oe,
        .lfo_clk, .wdt_restart, .reset_pin_n_in
    );
    initial
    begin
        core_clk = 1'h0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic results();
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            err_total++;
            results();
        end
    end
    task automatic wait_rst(input logic lvl, input int lim);
        int n = 0;
        while (sys_reset_n !== lvl && n < lim)
        begin
            @(negedge core_clk);
            n++;
        end
        `CHK(sys_reset_n, lvl)
    endtask
    // source held a while after taking, so release waits on it
    task automatic run_src(input logic [7:0] r, input logic oe_exp);
        req = r;
        wait_rst(1'h0, 20);
        repeat (4) @(negedge core_clk);
        `CHK(sys_reset_n, 1'h0)
        `CHK(reset_cause & r, r)
        `CHK(reset_pin_n_oe, oe_exp)
        `CHK(core_halt & irq_disable & timer_disable, 1'h1)
        req = 8'h00;
        wait_rst(1'h1, 20);
        @(negedge core_clk);
        `CHK({sys_reset_n, reset_pin_n_oe, wdt_enabled}, 3'h5)
    endtask
    initial
    begin
        repeat (2) @(negedge core_clk);
        `CHK(reset_cause, 8'h01)
        `CHK({reset_pin_n_oe, wdt_enabled, wdt_interval}, {2'h3, WDT_INTERVAL_MAX})
        `CHK(port_latch & port_open_drain, {NUM_PORT_PINS{1'h1}})
        `CHK({weak_pullup_en, ram_keep, fetch_addr}, {2'h3, RESET_VECTOR})
        `CHK({pc_clear, reset_pin_n_out, por_reset_n, sysclk_sel}, {3'h4, SYSCLK_SEL_INT})
        @(negedge core_clk);
        rst_n = 1'h1;
        wait_rst(1'h1, 20);
        // own pin drive must not come back as a pin reset
        repeat (3) @(negedge core_clk);
        `CHK({sys_reset_n, por_reset_n, reset_cause}, {2'h3, 8'h01})
        foreach (rows[i])
            run_src(rows[i][7:0], rows[i][8]);
        wdt_disable = 1'h1;
        @(negedge core_clk);
        wdt_disable = 1'h0;
        `CHK(wdt_enabled, 1'h0)
        wdt_lock = 1'h1;
        @(negedge core_clk);
        wdt_lock = 1'h0;
        wdt_disable = 1'h1;
        wdt_interval_wr = 1'h1;
        @(negedge core_clk);
        wdt_disable = 1'h0;
        wdt_interval_wr = 1'h0;
        `CHK({wdt_locked, wdt_enabled, wdt_interval}, {2'h3, WDT_INTERVAL_MAX})
        run_src(8'h08, 1'h0);
        `CHK(wdt_locked, 1'h0)
        kick_en = 1'h1;
        wdt_interval_wr = 1'h1;
        @(negedge core_clk);
        wdt_interval_wr = 1'h0;
        `CHK(wdt_interval, WDT_INTERVAL_MIN)
        repeat (6000) @(negedge core_clk);
        `CHK(sys_reset_n, 1'h1)
        kick_en = 1'h0;
        wait_rst(1'h0, 6000);
        `CHK({reset_cause[SRC_WDT], reset_pin_n_oe}, 2'h2)
        wait_rst(1'h1, 20);
        `CHK(wdt_interval, WDT_INTERVAL_MAX)
        results();
    end
endmodule
